// >>> hw/spc_map.vh
// spc_map.vh: register map, field positions, reset values and timing counts
// for the start-up profile and protection configuration block.
// assumes a 40 MHz core clock and 8-bit register addresses from the serial engine.
//
// Functional notes
// - range bit picks fast or slow tables
// - fast second-order codes 57 down to 0
// - slow second-order codes 0.22 down to 0
// - fast first-order codes 76 down to 0.3
// - slow first-order codes 4.8 down to 0.019
// - low threshold range is n times 0.8 Hz
// - high threshold range 12.8(n-16)+11.9 Hz
// - align hold 5.3 s halving to 0.04 s
// - protection register 0x94, zero reset, field layout
// - thermal cap off, 1, 1.6, 2 A
// - six lock detector enable bits
// - soft limit off or n times 0.2 A
// - hard limit two ranges by select bit
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

`define SPC_ADDR_STARTUP 8'h93
`define SPC_ADDR_PROTECT 8'h94

`define SPC_STARTUP_RST 16'h0000
`define SPC_PROTECT_RST 16'h0000
`define SPC_STARTUP_WMASK 16'h7fff

`define SPC_F_RESERVED 15
`define SPC_F_RANGE 14
`define SPC_F_ACC2_MSB 13
`define SPC_F_ACC2_LSB 11
`define SPC_F_ACC1_MSB 10
`define SPC_F_ACC1_LSB 8
`define SPC_F_THR_MSB 7
`define SPC_F_THR_LSB 3
`define SPC_F_ALIGN_MSB 2
`define SPC_F_ALIGN_LSB 0

`define SPC_F_TCAP_MSB 15
`define SPC_F_TCAP_LSB 14
`define SPC_F_LOCK_MSB 13
`define SPC_F_LOCK_LSB 8
`define SPC_F_SOFT_MSB 7
`define SPC_F_SOFT_LSB 4
`define SPC_F_HARD_MSB 3
`define SPC_F_HARD_LSB 1
`define SPC_F_HSEL 0

`define SPC_CLK_HZ 40000000
`define SPC_TICK_US 1000
`define SPC_TICK_CYCLES ((`SPC_CLK_HZ / 1000000) * `SPC_TICK_US)

// frequency accumulator unit is 1e-10 Hz
`define SPC_ACC1_SCALE 48'd10000
`define SPC_THR_SCALE 48'd1000000000

`endif

// >>> hw/spc_decode.v
// spc_decode.v: turns the two configuration words into physical quantities.
// assumes static inputs from registers; purely combinational, caller registers.
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.vh"

module spc_decode (
  // configuration words
  input wire [15:0] startup_cfg_i,
  input wire [15:0] protect_cfg_i,
  // start-up profile, units 1e-4 Hz/s2, mHz/s, 0.1 Hz, ms
  output reg [19:0] accel2_o,
  output reg [16:0] accel1_o,
  output reg [11:0] threshold_o,
  output reg [12:0] align_ms_o,
  // protection limits in mA
  output reg [11:0] thermal_cap_ma_o,
  output reg [11:0] soft_limit_ma_o,
  output reg [11:0] hard_limit_ma_o
);

  wire range_slow = startup_cfg_i[`SPC_F_RANGE];
  wire [2:0] acc2_code = startup_cfg_i[`SPC_F_ACC2_MSB:`SPC_F_ACC2_LSB];
  wire [2:0] acc1_code = startup_cfg_i[`SPC_F_ACC1_MSB:`SPC_F_ACC1_LSB];
  wire [4:0] thr_code = startup_cfg_i[`SPC_F_THR_MSB:`SPC_F_THR_LSB];
  wire [2:0] align_code = startup_cfg_i[`SPC_F_ALIGN_MSB:`SPC_F_ALIGN_LSB];
  wire [1:0] tcap_code = protect_cfg_i[`SPC_F_TCAP_MSB:`SPC_F_TCAP_LSB];
  wire [3:0] soft_code = protect_cfg_i[`SPC_F_SOFT_MSB:`SPC_F_SOFT_LSB];
  wire [2:0] hard_code = protect_cfg_i[`SPC_F_HARD_MSB:`SPC_F_HARD_LSB];
  wire hard_sel = protect_cfg_i[`SPC_F_HSEL];

  always @* begin
    case ({range_slow, acc2_code})
      4'h0: accel2_o = 20'd570000;
      4'h1: accel2_o = 20'd290000;
      4'h2: accel2_o = 20'd140000;
      4'h3: accel2_o = 20'd69000;
      4'h4: accel2_o = 20'd33000;
      4'h5: accel2_o = 20'd16000;
      4'h6: accel2_o = 20'd6600;
      4'h8: accel2_o = 20'd2200;
      4'h9: accel2_o = 20'd1100;
      4'ha: accel2_o = 20'd550;
      4'hb: accel2_o = 20'd270;
      4'hc: accel2_o = 20'd130;
      4'hd: accel2_o = 20'd63;
      4'he: accel2_o = 20'd26;
      default: accel2_o = 20'd0; // code 111 in either range
    endcase
  end

  always @* begin
    case ({range_slow, acc1_code})
      4'h0: accel1_o = 17'd76000;
      4'h1: accel1_o = 17'd38000;
      4'h2: accel1_o = 17'd19000;
      4'h3: accel1_o = 17'd9200;
      4'h4: accel1_o = 17'd4500;
      4'h5: accel1_o = 17'd2100;
      4'h6: accel1_o = 17'd900;
      4'h7: accel1_o = 17'd300;
      4'h8: accel1_o = 17'd4800;
      4'h9: accel1_o = 17'd2400;
      4'ha: accel1_o = 17'd1200;
      4'hb: accel1_o = 17'd580;
      4'hc: accel1_o = 17'd290;
      4'hd: accel1_o = 17'd130;
      4'he: accel1_o = 17'd60;
      default: accel1_o = 17'd19;
    endcase
  end

  always @* begin
    if (!thr_code[4]) begin
      threshold_o = {5'd0, thr_code[3:0], 3'd0};
    end else begin
      threshold_o = {1'b0, thr_code[3:0], 7'd0} + 12'd119;
    end
  end

  always @* begin
    case (align_code)
      3'd0: align_ms_o = 13'd5300;
      3'd1: align_ms_o = 13'd2700;
      3'd2: align_ms_o = 13'd1300;
      3'd3: align_ms_o = 13'd670;
      3'd4: align_ms_o = 13'd330;
      3'd5: align_ms_o = 13'd160;
      3'd6: align_ms_o = 13'd80;
      default: align_ms_o = 13'd40;
    endcase
  end

  always @* begin
    case (tcap_code)
      2'd1: thermal_cap_ma_o = 12'd1000;
      2'd2: thermal_cap_ma_o = 12'd1600;
      2'd3: thermal_cap_ma_o = 12'd2000;
      default: thermal_cap_ma_o = 12'd0;
    endcase
    soft_limit_ma_o = {1'b0, soft_code, 3'd0} * 12'd25;
    if (hard_sel) begin
      hard_limit_ma_o = ({9'd0, hard_code} + 12'd1) * 12'd400;
    end else begin
      case (hard_code[1:0])
        2'd0: hard_limit_ma_o = 12'd2500;
        2'd1: hard_limit_ma_o = 12'd1900;
        2'd2: hard_limit_ma_o = 12'd1500;
        default: hard_limit_ma_o = 12'd900;
      endcase
    end
  end

endmodule // spc_decode
`default_nettype wire

// >>> hw/spc_cfg.v
// spc_cfg.v: start-up profile and protection configuration registers with
// decoded outputs and the open-loop start-up sequencer.
// assumes the serial register engine presents single-cycle read/write strobes
// synchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.vh"

module spc_cfg #(
  parameter TICK_CYCLES = `SPC_TICK_CYCLES
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // register access from the serial engine
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  // start-up control
  input wire run_i,
  output reg [1:0] phase_o,
  output reg closed_loop_o,
  output reg [47:0] ol_freq_o,
  // decoded start-up profile
  output reg [19:0] accel2_o,
  output reg [16:0] accel1_o,
  output reg [11:0] threshold_o,
  output reg [12:0] align_ms_o,
  // decoded protection settings
  output reg [11:0] thermal_cap_ma_o,
  output reg [5:0] lock_en_o,
  output reg [11:0] soft_limit_ma_o,
  output reg [11:0] hard_limit_ma_o
);

  localparam ST_IDLE = 2'd0;
  localparam ST_ALIGN = 2'd1;
  localparam ST_RAMP = 2'd2;
  localparam ST_CLOSED = 2'd3;

  reg [15:0] startup_profile_config;
  reg [15:0] protection_limit_config;

  wire [19:0] dec_accel2;
  wire [16:0] dec_accel1;
  wire [11:0] dec_threshold;
  wire [12:0] dec_align_ms;
  wire [11:0] dec_tcap;
  wire [11:0] dec_soft;
  wire [11:0] dec_hard;

  // register file
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      startup_profile_config <= `SPC_STARTUP_RST;
      protection_limit_config <= `SPC_PROTECT_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `SPC_ADDR_STARTUP) begin
        // reserved top bit never stored
        startup_profile_config <= reg_wdata_i & `SPC_STARTUP_WMASK;
      end
      if (reg_addr_i == `SPC_ADDR_PROTECT) begin
        protection_limit_config <= reg_wdata_i;
      end
    end
  end

  // read data registered one cycle after the strobe; unmapped reads zero
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SPC_ADDR_STARTUP: reg_rdata_o <= startup_profile_config & `SPC_STARTUP_WMASK;
        `SPC_ADDR_PROTECT: reg_rdata_o <= protection_limit_config;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  spc_decode spc_decode_i (
    .startup_cfg_i(startup_profile_config),
    .protect_cfg_i(protection_limit_config),
    .accel2_o(dec_accel2),
    .accel1_o(dec_accel1),
    .threshold_o(dec_threshold),
    .align_ms_o(dec_align_ms),
    .thermal_cap_ma_o(dec_tcap),
    .soft_limit_ma_o(dec_soft),
    .hard_limit_ma_o(dec_hard)
  );

  // decoded values registered so every output leaves a flop
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      accel2_o <= 20'd0;
      accel1_o <= 17'd0;
      threshold_o <= 12'd0;
      align_ms_o <= 13'd0;
      thermal_cap_ma_o <= 12'd0;
      lock_en_o <= 6'd0;
      soft_limit_ma_o <= 12'd0;
      hard_limit_ma_o <= 12'd0;
    end else begin
      accel2_o <= dec_accel2;
      accel1_o <= dec_accel1;
      threshold_o <= dec_threshold;
      align_ms_o <= dec_align_ms;
      thermal_cap_ma_o <= dec_tcap;
      lock_en_o <= protection_limit_config[`SPC_F_LOCK_MSB:`SPC_F_LOCK_LSB];
      soft_limit_ma_o <= dec_soft;
      hard_limit_ma_o <= dec_hard;
    end
  end

  // millisecond tick; long count kept as a parameter so simulation can shrink it
  reg [31:0] tick_cnt;
  reg tick;

  always @(posedge core_clk_i) begin
    if (rst_i || phase_o == ST_IDLE) begin
      tick_cnt <= 32'd0;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 32'd0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'd1;
      tick <= 1'b0;
    end
  end

  // start-up sequencer
  reg [12:0] ms_cnt;
  reg [39:0] rate_acc;
  wire [47:0] thr_scaled = {36'd0, threshold_o} * `SPC_THR_SCALE;
  wire [47:0] acc1_scaled = {31'd0, accel1_o} * `SPC_ACC1_SCALE;
  wire [47:0] next_freq = ol_freq_o + acc1_scaled + {8'd0, rate_acc};
  // zero threshold code means no handover speed: go closed right after align
  wire no_thr = (threshold_o == 12'd0);

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      phase_o <= ST_IDLE;
      closed_loop_o <= 1'b0;
      ol_freq_o <= 48'd0;
      ms_cnt <= 13'd0;
      rate_acc <= 40'd0;
    end else if (!run_i) begin
      phase_o <= ST_IDLE;
      closed_loop_o <= 1'b0;
      ol_freq_o <= 48'd0;
      ms_cnt <= 13'd0;
      rate_acc <= 40'd0;
    end else begin
      case (phase_o)
        ST_IDLE: begin
          phase_o <= ST_ALIGN;
          ms_cnt <= 13'd0;
        end
        ST_ALIGN: begin
          if (tick) begin
            if (ms_cnt + 13'd1 >= align_ms_o) begin
              ms_cnt <= 13'd0;
              if (no_thr) begin
                phase_o <= ST_CLOSED;
                closed_loop_o <= 1'b1;
              end else begin
                phase_o <= ST_RAMP;
              end
            end else begin
              ms_cnt <= ms_cnt + 13'd1;
            end
          end
        end
        ST_RAMP: begin
          if (tick) begin
            // second-order term grows the slope every tick
            rate_acc <= rate_acc + {20'd0, accel2_o};
            ol_freq_o <= next_freq;
            if (next_freq >= thr_scaled) begin
              phase_o <= ST_CLOSED;
              closed_loop_o <= 1'b1;
            end
          end
        end
        ST_CLOSED: begin
          closed_loop_o <= 1'b1;
        end
        default: begin
          phase_o <= ST_IDLE;
          closed_loop_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // spc_cfg
`default_nettype wire

// >>> tb/spc_cfg_props.sv
// spc_cfg_props.sv: port assertions for the configuration block.
// assumes it is bound to every spc_cfg instance and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module spc_cfg_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  // run input, start-up and protection outputs
  input wire logic run_i,
  input wire logic [1:0] phase_o,
  input wire logic closed_loop_o,
  input wire logic [47:0] ol_freq_o,
  input wire logic [5:0] lock_en_o,
  input wire logic [11:0] soft_limit_ma_o
);
  logic [15:0] wd1;
  logic [15:0] wd2;
  logic pw1;
  logic pw2;
  // a reset between write and decode would clear the register, so drop the flag
  always @(posedge core_clk_i) begin
    wd1 <= reg_wdata_i;
    wd2 <= wd1;
    pw1 <= reg_wr_i && !rst_i && reg_addr_i == 8'h94;
    pw2 <= pw1 && !rst_i;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_unmapped_read_zero: assert property (reg_rd_i && reg_addr_i != 8'h93 && reg_addr_i != 8'h94 |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  a_reserved_reads_zero: assert property (reg_rd_i && reg_addr_i == 8'h93 |=> !reg_rdata_o[15]) else $error("reserved bit set");
  a_lock_follows_write: assert property (pw2 |-> lock_en_o == wd2[13:8]) else $error("lock enables differ");
  a_soft_follows_write: assert property (pw2 |-> soft_limit_ma_o == 12'd200 * {8'h00, wd2[7:4]}) else $error("soft limit differs");
  a_idle_to_align: assert property (phase_o == 2'd0 && run_i |=> phase_o == 2'd1) else $error("align not entered");
  a_abort_to_idle: assert property (!run_i |=> phase_o == 2'd0 && ol_freq_o == 48'h0) else $error("abort ignored");
  a_closed_flag_phase: assert property (closed_loop_o == (phase_o == 2'd3)) else $error("closed flag wrong");
  a_ramp_forward: assert property (phase_o == 2'd2 && run_i |=> phase_o inside {2'd2, 2'd3}) else $error("ramp left wrongly");
  c_closed: cover property (phase_o == 2'd2 ##1 phase_o == 2'd3);
  c_unmapped: cover property (reg_rd_i && reg_addr_i == 8'h95);
  c_prot_write: cover property (pw2);
endmodule // spc_cfg_props
bind spc_cfg spc_cfg_props spc_cfg_props_i (.core_clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .run_i, .phase_o, .closed_loop_o, .ol_freq_o,
  .lock_en_o, .soft_limit_ma_o);
`default_nettype wire

// >>> tb/spc_host.sv
// spc_host.sv: host model issuing single-cycle register strobes.
// assumes the bench calls its tasks; drives at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module spc_host (
  // clock and read data
  input wire logic core_clk_i,
  input wire logic [15:0] rdata_i,
  // strobes
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] wdata_o
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge core_clk_i);
    wr_o = 1'b0;
    wdata_o = ~d; // stale data must not look valid
  endtask
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    @(negedge core_clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge core_clk_i);
    rd_o = 1'b0;
    d = rdata_i;
  endtask
endmodule // spc_host
`default_nettype wire

// >>> tb/spc_cfg_tb_top.sv
// spc_cfg_tb_top.sv: self-checking bench for the configuration block.
// assumes a short tick so the start-up sequence fits in a short run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0d got %0d", n, e, s); end end
module spc_cfg_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic run_i = 1'b0;
  logic [7:0] reg_addr_i;
  logic reg_wr_i, reg_rd_i, closed_loop_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, w, r;
  logic [1:0] phase_o;
  logic [47:0] ol_freq_o;
  logic [19:0] accel2_o;
  logic [16:0] accel1_o;
  logic [11:0] threshold_o, thermal_cap_ma_o, soft_limit_ma_o, hard_limit_ma_o;
  logic [12:0] align_ms_o;
  logic [5:0] lock_en_o;
  logic [4:0] t;
  int miscompares = 0, compares = 0, n, seen;
  int a2 [16] = '{570000, 290000, 140000, 69000, 33000, 16000, 6600, 0,
                  2200, 1100, 550, 270, 130, 63, 26, 0};
  int a1 [16] = '{76000, 38000, 19000, 9200, 4500, 2100, 900, 300,
                  4800, 2400, 1200, 580, 290, 130, 60, 19};
  int al [8] = '{5300, 2700, 1300, 670, 330, 160, 80, 40};
  int tc [4] = '{0, 1000, 1600, 2000};
  int hd [4] = '{2500, 1900, 1500, 900};
  always #12.5 core_clk_i = ~core_clk_i;
  spc_cfg #(.TICK_CYCLES(4)) spc_cfg_i (.core_clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .run_i, .phase_o, .closed_loop_o, .ol_freq_o,
    .accel2_o, .accel1_o, .threshold_o, .align_ms_o, .thermal_cap_ma_o, .lock_en_o,
    .soft_limit_ma_o, .hard_limit_ma_o);
  spc_host spc_host_i (.core_clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // run the start-up sequence until closed loop, counting cycles
  task automatic start(input logic [15:0] cfg);
    spc_host_i.write(8'h93, cfg);
    @(negedge core_clk_i) run_i = 1'b1;
    @(negedge core_clk_i);
    `CHK("phase", 1, phase_o)
    n = 0;
    seen = 0;
    while (phase_o !== 2'd3 && n < 600) begin
      @(negedge core_clk_i);
      if (phase_o === 2'd2) seen = 1;
      n++;
    end
  endtask
  initial begin
    #(25 * 4000);
    miscompares++;
    results();
  end
  initial begin
    repeat (10) @(negedge core_clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      t = 5'(i * 3);
      w = {1'b0, i[3], i[2:0], i[2:0], t, i[2:0]}; // host leaves reserved bit clear
      spc_host_i.write(8'h93, w);
      spc_host_i.read(8'h93, r);
      `CHK("startup", w & 16'h7fff, r)
      `CHK("accel2", a2[i], accel2_o)
      `CHK("accel1", a1[i], accel1_o)
      `CHK("thr", t < 16 ? t * 8 : 128 * (t - 16) + 119, threshold_o)
      `CHK("align", al[i % 8], align_ms_o)
      w = {i[1:0], 6'(1 << (i % 6)), i[3:0], i[2:0], i[3]};
      spc_host_i.write(8'h94, w);
      spc_host_i.read(8'h94, r);
      `CHK("protect", w, r)
      `CHK("tcap", tc[i % 4], thermal_cap_ma_o)
      `CHK("lock", w[13:8], lock_en_o)
      `CHK("soft", i * 200, soft_limit_ma_o)
      `CHK("hard", i[3] ? 400 * (i % 8 + 1) : hd[i % 4], hard_limit_ma_o)
    end
    // mid-run reset clears both words and the decode
    @(negedge core_clk_i) rst_i = 1'b1;
    @(negedge core_clk_i) rst_i = 1'b0;
    spc_host_i.read(8'h94, r);
    `CHK("prot rst", 0, r)
    spc_host_i.read(8'h93, r);
    `CHK("start rst", 0, r)
    `CHK("hard rst", 2500, hard_limit_ma_o)
    spc_host_i.read(8'h95, r);
    `CHK("unmapped", 0, r)
    // no threshold: straight to closed loop after 40 ticks of align
    start(16'h0007);
    `CHK("closed", 1'b1, closed_loop_o)
    `CHK("align len", 1, n > 150 && n < 170)
    @(negedge core_clk_i) run_i = 1'b0;
    @(negedge core_clk_i);
    `CHK("abort", 0, phase_o)
    start(16'h000f);
    `CHK("ramped", 1, seen)
    `CHK("handover", 1, ol_freq_o >= 48'd8000000000)
    results();
  end
endmodule // spc_cfg_tb_top
`default_nettype wire
